// ### hw/sld_driver.sv
// Segment LCD driver top: AHB-Lite registers, display buffer, pin remap, levels.
// Assumes oscillator ticks are one-cycle pulses on hclk; analog parts outside.
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

`include "sld_params.svh"

module sld_driver
  import sld_pkg::*;
#(
  parameter int NUM_PINS = `SLD_NUM_PINS,
  parameter int MAX_COM = `SLD_MAX_COM,
  parameter int NUM_SEG = `SLD_NUM_SEG
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic low_speed_rc_clock,
  input wire logic high_speed_rc_clock,
  input wire logic external_32k_crystal,
  output logic [NUM_PINS-1:0][2:0] pin_level,
  output logic [NUM_PINS-1:0] pin_oe,
  output logic [2:0] bias_den,
  output logic [1:0] display_mode,
  output logic [2:0] drive_intensity,
  output logic [1:0] drive_current_sel,
  output logic pump_enable,
  output logic [2:0] pump_clk_div,
  output logic [12:0] pump_vout_mv
);

  sld_tick_if tick ();

  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] cfg_q, cfg_d;
  logic [7:0] pump_q, pump_d;
  logic [11:0] div_q, div_d;
  logic [7:0] index_q, index_d;
  logic [NUM_PINS-1:0] pin_en_q, pin_en_d;
  logic [NUM_PINS-1:0] pin_com_q, pin_com_d;
  logic [7:0] buf_q [NUM_SEG];
  logic [7:0] buf_d [NUM_SEG];
  logic wr_pend_q, wr_pend_d;
  logic [8:0] widx_q, widx_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic [NUM_PINS-1:0][2:0] level_q, level_d;
  logic [NUM_PINS-1:0] oe_q, oe_d;
  logic [2:0] bias_q, bias_d;
  logic [2:0] inten_q, inten_d;
  logic [1:0] cur_q, cur_d;
  logic [12:0] mv_q, mv_d;

  logic acc;
  logic mapped_hi;
  logic [8:0] ridx;
  logic [1:0] mode;
  logic [2:0] ncom;
  logic [2:0] slot;
  logic [11:0] slot_prod;
  logic drive_on;
  logic [NUM_PINS-1:0][5:0] lnum;
  logic [5:0] ccnt;
  logic [5:0] scnt;

  sld_timebase u_timebase (
    .hclk(hclk),
    .hresetn(hresetn),
    .low_tick(low_speed_rc_clock),
    .high_tick(high_speed_rc_clock),
    .xtal_tick(external_32k_crystal),
    .tb(tick.tb)
  );

  assign tick.src_sel = ctrl_q[`SLD_CTRL_SRC_LSB +: 3];
  assign tick.div = div_q;
  assign mode = ctrl_q[`SLD_CTRL_MODE_LSB +: 2];

  // Bus: address phase, then write data lands in the following cycle
  always_comb begin
    acc = hsel && hready && htrans[1];
    mapped_hi = (haddr[31:11] == 21'h000000);
    ridx = haddr[10:2];
    wr_pend_d = acc && hwrite && mapped_hi;
    widx_d = wr_pend_d ? ridx : widx_q;
    ctrl_d = ctrl_q;
    cfg_d = cfg_q;
    pump_d = pump_q;
    div_d = div_q;
    index_d = index_q;
    pin_en_d = pin_en_q;
    pin_com_d = pin_com_q;
    buf_d = buf_q;
    if (wr_pend_q) begin
      case (widx_q)
        `SLD_IDX_CTRL: ctrl_d = hwdata[7:0] & `SLD_CTRL_WMASK;
        `SLD_IDX_CFG: cfg_d = hwdata[7:0] & `SLD_CFG_WMASK;
        `SLD_IDX_PUMP: pump_d = hwdata[7:0] & `SLD_PUMP_WMASK;
        `SLD_IDX_DIVL: div_d = {div_q[11:8], hwdata[7:0]};
        `SLD_IDX_DIVH: div_d = {hwdata[3:0], div_q[7:0]};
        `SLD_IDX_INDEX: index_d = hwdata[7:0];
        `SLD_IDX_PINEN_LO: pin_en_d = {pin_en_q[NUM_PINS-1:32], hwdata};
        `SLD_IDX_PINEN_HI: pin_en_d = {hwdata[NUM_PINS-33:0], pin_en_q[31:0]};
        `SLD_IDX_PINCOM_LO: pin_com_d = {pin_com_q[NUM_PINS-1:32], hwdata};
        `SLD_IDX_PINCOM_HI: pin_com_d = {hwdata[NUM_PINS-33:0], pin_com_q[31:0]};
        `SLD_IDX_DATA: begin
          if (index_q < 8'(NUM_SEG)) begin
            buf_d[index_q[4:0]] = hwdata[7:0];
          end
        end
        default: ;
      endcase
    end
  end

  // Read data uses next values so a read right behind a write sees it
  always_comb begin
    hrdata_d = 32'h00000000;
    if (acc && !hwrite && mapped_hi) begin
      case (ridx)
        `SLD_IDX_CTRL: hrdata_d = {24'h000000, ctrl_d};
        `SLD_IDX_CFG: hrdata_d = {24'h000000, cfg_d};
        `SLD_IDX_PUMP: hrdata_d = {24'h000000, pump_d};
        `SLD_IDX_DIVL: hrdata_d = {24'h000000, div_d[7:0]};
        `SLD_IDX_DIVH: hrdata_d = {28'h0000000, div_d[11:8]};
        `SLD_IDX_INDEX: hrdata_d = {24'h000000, index_d};
        `SLD_IDX_PINEN_LO: hrdata_d = pin_en_d[31:0];
        `SLD_IDX_PINEN_HI: hrdata_d = {28'h0000000, pin_en_d[NUM_PINS-1:32]};
        `SLD_IDX_PINCOM_LO: hrdata_d = pin_com_d[31:0];
        `SLD_IDX_PINCOM_HI: hrdata_d = {28'h0000000, pin_com_d[NUM_PINS-1:32]};
        `SLD_IDX_STATUS: hrdata_d = {24'h000000, tick.pol, slot, ncom, tick.running};
        `SLD_IDX_DATA: begin
          if (index_d < 8'(NUM_SEG)) begin
            hrdata_d = {24'h000000, buf_d[index_d[4:0]]};
          end
        end
        default: hrdata_d = 32'h00000000;
      endcase
    end
  end

  // Pin remap: count enabled pins of each kind below each pin
  always_comb begin
    ccnt = 6'h00;
    scnt = 6'h00;
    for (int p = 0; p < NUM_PINS; p++) begin
      lnum[p] = pin_com_q[p] ? ccnt : scnt;
      if (pin_en_q[p] && pin_com_q[p]) begin
        ccnt = ccnt + 6'h01;
      end
      if (pin_en_q[p] && !pin_com_q[p]) begin
        scnt = scnt + 6'h01;
      end
    end
    ncom = (ccnt > 6'(MAX_COM)) ? 3'(MAX_COM) : ccnt[2:0];
    slot_prod = 12'(tick.step) * 12'(ncom);
    slot = slot_prod[11:9];
    drive_on = tick.running && ctrl_q[`SLD_CTRL_OE_BIT] && (ncom != 3'h0);
  end

  // Panel levels in steps of supply/bias; polarity flips each frame
  always_comb begin
    bias_d = sld_bias_of(mode, cfg_q[`SLD_CFG_BIAS_LSB +: 2]);
    for (int p = 0; p < NUM_PINS; p++) begin
      level_d[p] = 3'h0;
      oe_d[p] = 1'b0;
      if (pin_com_q[p]) begin
        if (drive_on && pin_en_q[p] && lnum[p] < 6'(MAX_COM)) begin
          oe_d[p] = 1'b1;
          if (lnum[p][2:0] == slot) begin
            level_d[p] = tick.pol ? 3'h0 : bias_d;
          end else begin
            level_d[p] = tick.pol ? bias_d - 3'h1 : 3'h1;
          end
        end
      end else begin
        // byte per segment, bit per common
        if (drive_on && pin_en_q[p] && lnum[p] < 6'(NUM_SEG)) begin
          oe_d[p] = 1'b1;
          if (buf_q[lnum[p][4:0]][slot]) begin
            level_d[p] = tick.pol ? bias_d : 3'h0;
          end else begin
            level_d[p] = tick.pol ? 3'h1 : bias_d - 3'h1;
          end
        end
      end
      if (!oe_d[p]) begin
        level_d[p] = 3'h0;
      end
    end
  end

  // Analog controls: each field only where its mode uses it
  always_comb begin
    inten_d = 3'h0;
    cur_d = 2'h0;
    mv_d = 13'h0000;
    case (mode)
      `SLD_MODE_RES, `SLD_MODE_RESALT: begin
        inten_d = cfg_q[`SLD_CFG_LVL_LSB +: 3];
        cur_d = cfg_q[`SLD_CFG_CUR_LSB +: 2];
      end
      `SLD_MODE_REGPUMP: begin
        // 2.4 V plus 0.3 V steps
        mv_d = `SLD_VREG_BASE_MV + 13'(`SLD_VREG_STEP_MV * cfg_q[`SLD_CFG_LVL_LSB +: 3]);
      end
      default: begin
        mv_d = 13'h0000;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `SLD_CTRL_RESET;
      cfg_q <= `SLD_CFG_RESET;
      pump_q <= `SLD_PUMP_RESET;
      div_q <= `SLD_DIV_RESET;
      index_q <= `SLD_INDEX_RESET;
      pin_en_q <= '0;
      pin_com_q <= '0;
      for (int i = 0; i < NUM_SEG; i++) begin
        buf_q[i] <= 8'h00;
      end
      wr_pend_q <= 1'b0;
      widx_q <= 9'h000;
      hrdata_q <= 32'h00000000;
      level_q <= '0;
      oe_q <= '0;
      bias_q <= `SLD_BIAS_QUARTER;
      inten_q <= 3'h0;
      cur_q <= 2'h0;
      mv_q <= 13'h0000;
    end else begin
      ctrl_q <= ctrl_d;
      cfg_q <= cfg_d;
      pump_q <= pump_d;
      div_q <= div_d;
      index_q <= index_d;
      pin_en_q <= pin_en_d;
      pin_com_q <= pin_com_d;
      buf_q <= buf_d;
      wr_pend_q <= wr_pend_d;
      widx_q <= widx_d;
      hrdata_q <= hrdata_d;
      level_q <= level_d;
      oe_q <= oe_d;
      bias_q <= bias_d;
      inten_q <= inten_d;
      cur_q <= cur_d;
      mv_q <= mv_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign pin_level = level_q;
  assign pin_oe = oe_q;
  assign bias_den = bias_q;
  assign display_mode = mode;
  assign drive_intensity = inten_q;
  assign drive_current_sel = cur_q;
  // pump bit kept apart from output enable
  assign pump_enable = pump_q[`SLD_PUMP_EN_BIT];
  assign pump_clk_div = pump_q[`SLD_PUMP_CKD_LSB +: 3];
  assign pump_vout_mv = mv_q;

endmodule

`default_nettype wire

// ### hw/sld_params.svh
// Constants of the segment LCD driver: offsets, fields, reset values, counts.
// Assumes the package includes it once; registers sit at index*4 on AHB-Lite.
`ifndef SLD_PARAMS_SVH
`define SLD_PARAMS_SVH

`define SLD_IDX_CTRL 9'h0e1
`define SLD_IDX_CFG 9'h0e2
`define SLD_IDX_DATA 9'h0e3
`define SLD_IDX_DIVL 9'h0e4
`define SLD_IDX_DIVH 9'h0e5
`define SLD_IDX_INDEX 9'h0f0
`define SLD_IDX_PUMP 9'h116
`define SLD_IDX_PINEN_LO 9'h120
`define SLD_IDX_PINEN_HI 9'h121
`define SLD_IDX_PINCOM_LO 9'h122
`define SLD_IDX_PINCOM_HI 9'h123
`define SLD_IDX_STATUS 9'h124

`define SLD_CTRL_SRC_LSB 5
`define SLD_CTRL_MODE_LSB 1
`define SLD_CTRL_OE_BIT 0
`define SLD_CTRL_WMASK 8'he7
`define SLD_CFG_CUR_LSB 6
`define SLD_CFG_BIAS_LSB 4
`define SLD_CFG_LVL_LSB 0
`define SLD_CFG_WMASK 8'hf7
`define SLD_PUMP_EN_BIT 0
`define SLD_PUMP_CKD_LSB 1
`define SLD_PUMP_WMASK 8'h0f
`define SLD_DIVH_WMASK 8'h0f

`define SLD_CTRL_RESET 8'h00
`define SLD_CFG_RESET 8'h00
`define SLD_PUMP_RESET 8'h00
`define SLD_DIV_RESET 12'h000
`define SLD_INDEX_RESET 8'h00

`define SLD_SRC_LOW 3'h1
`define SLD_SRC_HIGH 3'h2
`define SLD_SRC_XTAL 3'h3
`define SLD_MODE_RES 2'h0
`define SLD_MODE_PUMPDIV 2'h1
`define SLD_MODE_REGPUMP 2'h2
`define SLD_MODE_RESALT 2'h3
`define SLD_BIAS_HALF_CODE 2'h1
`define SLD_BIAS_THIRD_CODE 2'h2
`define SLD_BIAS_HALF 3'h2
`define SLD_BIAS_THIRD 3'h3
`define SLD_BIAS_QUARTER 3'h4

`define SLD_FRAME_STEPS 512
`define SLD_LOW_PRESCALE 4
`define SLD_VREG_BASE_MV 13'h0960
`define SLD_VREG_STEP_MV 13'h012c
`define SLD_NUM_PINS 36
`define SLD_MAX_COM 5
`define SLD_NUM_SEG 32

`endif

// ### hw/sld_pkg.sv
// Types shared by the segment LCD driver modules.
// Assumes sld_params.svh lies on the include path.
`include "sld_params.svh"

package sld_pkg;

  typedef enum logic [2:0] {
    SLD_SRC_OFF = 3'h0,
    SLD_SRC_LOW = `SLD_SRC_LOW,
    SLD_SRC_HIGH = `SLD_SRC_HIGH,
    SLD_SRC_XTAL = `SLD_SRC_XTAL
  } sld_src_t;

  typedef enum logic [1:0] {
    SLD_MODE_RES = `SLD_MODE_RES,
    SLD_MODE_PUMPDIV = `SLD_MODE_PUMPDIV,
    SLD_MODE_REGPUMP = `SLD_MODE_REGPUMP,
    SLD_MODE_RESALT = `SLD_MODE_RESALT
  } sld_mode_t;

  typedef logic [2:0] sld_level_t;

  // Bias denominator in force for a mode and bias field
  function automatic logic [2:0] sld_bias_of(input logic [1:0] mode, input logic [1:0] field);
    if (mode == `SLD_MODE_PUMPDIV || mode == `SLD_MODE_REGPUMP) begin
      return `SLD_BIAS_THIRD;
    end
    if (field == `SLD_BIAS_HALF_CODE) begin
      return `SLD_BIAS_HALF;
    end
    if (field == `SLD_BIAS_THIRD_CODE) begin
      return `SLD_BIAS_THIRD;
    end
    return `SLD_BIAS_QUARTER;
  endfunction

endpackage

// ### hw/sld_tick_if.sv
// Carrier between the register side and the frame timebase.
// Assumes both ends run on hclk.
`timescale 1ns/1ps
`default_nettype none

interface sld_tick_if;
  logic [2:0] src_sel;
  logic [11:0] div;
  logic running;
  logic [8:0] step;
  logic pol;
  modport drv (output src_sel, output div, input running, input step, input pol);
  modport tb (input src_sel, input div, output running, output step, output pol);
endinterface

`default_nettype wire

// ### hw/sld_timebase.sv
// Frame timebase: picks a source tick, prescales, counts 512 steps per frame.
// Assumes source ticks are one-cycle pulses synchronous to hclk.
`timescale 1ns/1ps
`default_nettype none

`include "sld_params.svh"

module sld_timebase
  import sld_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic low_tick,
  input wire logic high_tick,
  input wire logic xtal_tick,
  sld_tick_if.tb tb
);

  logic [1:0] quarter_q, quarter_d;
  logic [11:0] pre_q, pre_d;
  logic [8:0] step_q, step_d;
  logic pol_q, pol_d;
  logic run_q, run_d;
  logic src_tick;
  logic drv_tick;

  always_comb begin
    case (tb.src_sel)
      `SLD_SRC_LOW: src_tick = low_tick;
      `SLD_SRC_HIGH: src_tick = high_tick;
      `SLD_SRC_XTAL: src_tick = xtal_tick;
      default: src_tick = 1'b0;
    endcase
    run_d = (tb.src_sel == `SLD_SRC_LOW) || (tb.src_sel == `SLD_SRC_HIGH) || (tb.src_sel == `SLD_SRC_XTAL);
    quarter_d = quarter_q;
    pre_d = pre_q;
    step_d = step_q;
    pol_d = pol_q;
    drv_tick = 1'b0;
    if (!run_d) begin
      quarter_d = 2'h0;
      pre_d = 12'h000;
      step_d = 9'h000;
      pol_d = 1'b0;
    end else if (src_tick) begin
      if (tb.src_sel == `SLD_SRC_LOW) begin
        quarter_d = quarter_q + 2'h1;
        drv_tick = (quarter_q == 2'(`SLD_LOW_PRESCALE - 1));
      end else begin
        drv_tick = 1'b1;
      end
    end
    if (run_d && drv_tick) begin
      if (pre_q >= tb.div) begin
        pre_d = 12'h000;
        step_d = step_q + 9'h001;
        if (step_q == 9'(`SLD_FRAME_STEPS - 1)) begin
          pol_d = ~pol_q;
        end
      end else begin
        pre_d = pre_q + 12'h001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      quarter_q <= 2'h0;
      pre_q <= 12'h000;
      step_q <= 9'h000;
      pol_q <= 1'b0;
      run_q <= 1'b0;
    end else begin
      quarter_q <= quarter_d;
      pre_q <= pre_d;
      step_q <= step_d;
      pol_q <= pol_d;
      run_q <= run_d;
    end
  end

  assign tb.running = run_q;
  assign tb.step = step_q;
  assign tb.pol = pol_q;

endmodule

`default_nettype wire

// ### test/sld_glass.sv
// Glass model: a pixel line looks dark when its pin sits at a rail level.
// Assumes the driver's digital level steps, with bias_den as the top rail.
`timescale 1ns/1ps
`default_nettype none
module sld_glass #(
  parameter int NUM_PINS = 36
) (
  input wire logic [NUM_PINS-1:0][2:0] pin_level,
  input wire logic [NUM_PINS-1:0] pin_oe,
  input wire logic [2:0] bias_den,
  output logic [NUM_PINS-1:0] dark
);
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      dark[i] = pin_oe[i] && (pin_level[i] == 3'h0 || pin_level[i] == bias_den);
    end
  end
endmodule
`default_nettype wire

// ### test/sld_driver_monitor.sv
// Port checker of the segment LCD driver.
// Assumes it is bound to sld_driver and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "sld_params.svh"
module sld_monitor #(
  parameter int NUM_PINS = `SLD_NUM_PINS,
  parameter int MAX_COM = `SLD_MAX_COM,
  parameter int NUM_SEG = `SLD_NUM_SEG
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [NUM_PINS-1:0][2:0] pin_level,
  input wire logic [NUM_PINS-1:0] pin_oe,
  input wire logic [2:0] bias_den,
  input wire logic [1:0] display_mode,
  input wire logic [2:0] drive_intensity,
  input wire logic [1:0] drive_current_sel,
  input wire logic [12:0] pump_vout_mv
);
  logic stray;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  always_comb begin
    stray = 1'b0;
    for (int i = 0; i < NUM_PINS; i++) begin
      if (!pin_oe[i] && pin_level[i] != 3'h0) begin
        stray = 1'b1;
      end
    end
  end
  ready_high_a: assert property (hreadyout)
    else $error("hreadyout low");
  resp_okay_a: assert property (!hresp)
    else $error("error response");
  rdata_idle_a: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> hrdata == 32'h0)
    else $error("hrdata not zero outside read");
  pumpdiv_fixed_a: assert property (display_mode == 2'h1 |=>
    bias_den == 3'h3 && drive_intensity == 3'h0 && drive_current_sel == 2'h0 && pump_vout_mv == 13'h0)
    else $error("pump division outputs wrong");
  regpump_fixed_a: assert property (display_mode == 2'h2 |=>
    bias_den == 3'h3 && drive_intensity == 3'h0 && drive_current_sel == 2'h0)
    else $error("regulated pump outputs wrong");
  vout_range_a: assert property (display_mode == 2'h2 |=> pump_vout_mv >= 13'h0960 &&
    pump_vout_mv <= 13'h1194 && (pump_vout_mv - 13'h0960) % 13'h012c == 13'h0)
    else $error("pump voltage off grid");
  res_mode_a: assert property (display_mode[0] == display_mode[1] |=>
    pump_vout_mv == 13'h0 && bias_den inside {3'h2, 3'h3, 3'h4})
    else $error("resistive outputs wrong");
  undriven_pin_a: assert property (!stray)
    else $error("level on undriven pin");
  cover property (display_mode == 2'h2 ##1 pump_vout_mv == 13'h1194);
  cover property (hsel && htrans[1] && !hwrite);
  cover property ($rose(pin_oe[0]));
endmodule
bind sld_driver sld_monitor #(.NUM_PINS(NUM_PINS), .MAX_COM(MAX_COM), .NUM_SEG(NUM_SEG)) mon (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .pin_level(pin_level), .pin_oe(pin_oe), .bias_den(bias_den), .display_mode(display_mode),
  .drive_intensity(drive_intensity), .drive_current_sel(drive_current_sel), .pump_vout_mv(pump_vout_mv));
`default_nettype wire

// ### test/sld_driver_tb.sv
// Testbench of the segment LCD driver: AHB-Lite register traffic, pin checks.
// Assumes oscillator ticks as pulses every other hclk.
`timescale 1ns/1ps
`default_nettype none
`include "sld_params.svh"
module sld_driver_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic tk = 1'b0;
  logic hreadyout, hresp, pump_enable;
  logic [31:0] hrdata, rd;
  logic [35:0][2:0] pin_level;
  logic [35:0] pin_oe, dark;
  logic [2:0] bias_den, drive_intensity, pump_clk_div;
  logic [1:0] display_mode, drive_current_sel;
  logic [12:0] pump_vout_mv;
  int errors = 0;
  int samples_checked = 0;
  always #12.5 hclk = ~hclk;
  always @(posedge hclk) tk <= ~tk;
  sld_driver DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .low_speed_rc_clock(tk), .high_speed_rc_clock(tk),
    .external_32k_crystal(tk), .pin_level(pin_level), .pin_oe(pin_oe), .bias_den(bias_den),
    .display_mode(display_mode), .drive_intensity(drive_intensity),
    .drive_current_sel(drive_current_sel), .pump_enable(pump_enable),
    .pump_clk_div(pump_clk_div), .pump_vout_mv(pump_vout_mv));
  sld_glass glass (.pin_level(pin_level), .pin_oe(pin_oe), .bias_den(bias_den), .dark(dark));
  task automatic wrap_up;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wt;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      errors++;
      wrap_up();
    end
  endtask
  task automatic bus(input logic w, input logic [8:0] idx, input logic [7:0] wd);
    hsel <= 1'b1;
    haddr <= {21'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    wt();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    wt();
    rd = hrdata;
  endtask
  task automatic wr(input logic [8:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask
  task automatic rdc(input logic [8:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h0);
    chk({4'h0, rd}, {28'h0, e});
  endtask
  task automatic oe_is(input logic [35:0] e);
    int n;
    n = 0;
    while (pin_oe !== e && n < 40) begin
      @(posedge hclk);
      n++;
    end
    chk(pin_oe, e);
  endtask
  task automatic frame(input int e);
    int n;
    logic [2:0] l;
    for (int k = 0; k < 3; k++) begin
      n = 0;
      l = pin_level[0];
      while (pin_level[0] === l && n < 9000) begin
        @(posedge hclk);
        n++;
      end
    end
    chk(36'(n), 36'(e));
  endtask
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(`SLD_IDX_CTRL, 8'h00);
    wr(`SLD_IDX_CTRL, 8'h18);
    rdc(`SLD_IDX_CTRL, 8'h00);
    rdc(9'h1ff, 8'h00);
    for (int i = 0; i < 33; i++) begin
      wr(`SLD_IDX_INDEX, 8'(i));
      wr(`SLD_IDX_DATA, 8'(i ^ 8'h15));
    end
    for (int i = 32; i >= 0; i--) begin
      wr(`SLD_IDX_INDEX, 8'(i));
      rdc(`SLD_IDX_DATA, (i < 32) ? 8'(i ^ 8'h15) : 8'h00);
    end
    for (int m = 0; m < 4; m++) begin
      wr(`SLD_IDX_CTRL, {3'h2, 2'h0, 2'(m), 1'b0});
      for (int v = 0; v < 8; v++) begin
        wr(`SLD_IDX_CFG, {2'(v), 2'(v), 1'b0, 3'(v)});
        repeat (2) @(posedge hclk);
        chk({display_mode, bias_den, drive_intensity, drive_current_sel, pump_vout_mv},
          {2'(m), (m == 1 || m == 2) ? 3'h3 : (v % 4 == 1) ? 3'h2 : (v % 4 == 2) ? 3'h3 : 3'h4,
          (m == 0 || m == 3) ? 3'(v) : 3'h0, (m == 0 || m == 3) ? 2'(v) : 2'h0,
          (m == 2) ? 13'(2400 + 300 * v) : 13'h0});
      end
    end
    wr(`SLD_IDX_PUMP, 8'hf5);
    rdc(`SLD_IDX_PUMP, 8'h05);
    chk({pump_enable, pump_clk_div}, 4'ha);
    wr(`SLD_IDX_PINEN_LO, 8'h5a);
    wr(`SLD_IDX_PINCOM_LO, 8'h0a);
    wr(`SLD_IDX_INDEX, 8'h00);
    wr(`SLD_IDX_DATA, 8'h1f);
    wr(`SLD_IDX_INDEX, 8'h01);
    wr(`SLD_IDX_DATA, 8'h00);
    wr(`SLD_IDX_CFG, 8'h00);
    for (int s = 0; s < 8; s++) begin
      wr(`SLD_IDX_CTRL, {3'(s), 5'h01});
      oe_is((s > 0 && s < 4) ? 36'h5a : 36'h0);
    end
    wr(`SLD_IDX_CTRL, 8'h41);
    oe_is(36'h5a);
    repeat (3) @(posedge hclk);
    chk({dark[6], dark[4], dark[1] ^ dark[3]}, 3'h3);
    bus(1'b0, `SLD_IDX_STATUS, 8'h0);
    chk({rd[3:1], rd[0]}, 4'h5);
    repeat (600) @(posedge hclk);
    chk({dark[1], dark[3]}, 2'h1);
    wr(`SLD_IDX_PINEN_LO, 8'h51);
    wr(`SLD_IDX_PINCOM_LO, 8'h01);
    frame(1024);
    wr(`SLD_IDX_DIVL, 8'h01);
    frame(2048);
    wr(`SLD_IDX_DIVL, 8'h00);
    wr(`SLD_IDX_CTRL, 8'h21);
    frame(4096);
    wr(`SLD_IDX_CTRL, 8'h61);
    frame(1024);
    wr(`SLD_IDX_DIVH, 8'hff);
    rdc(`SLD_IDX_DIVH, 8'h0f);
    wrap_up();
  end
endmodule
`default_nettype wire
